/* hdl/sra_defs.svh */
// Purpose: constants of the smbus ram/eeprom access block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH

// ----------------------------------------
// slave address and command codes
// ----------------------------------------
`define SRA_DEV_ADDR_HI 4'ha
`define SRA_CMD_BLK_WR 8'ha0
`define SRA_CMD_BLK_RD 8'ha1
`define SRA_CMD_ERASE 8'ha2

// ----------------------------------------
// address map and limits
// ----------------------------------------
`define SRA_RAM_HI 8'h00
`define SRA_EE_HI_FRU 8'h80
`define SRA_EE_HI_CFG 8'h81
`define SRA_RAM_LIMIT 8'h7f
`define SRA_EE_FRU_LAST 8'hff
`define SRA_EE_CFG_LAST 8'h3f
`define SRA_PAGE_LAST 5'h1f
`define SRA_PAGE_BYTES 32
`define SRA_BLK_MAX 8'h20
`define SRA_WP_REG 7'h03
`define SRA_WP_BIT 1
`define SRA_EE_ERASED 8'hff
`define SRA_EE_BYTES 320
`define SRA_RAM_BYTES 128

// ----------------------------------------
// timing and fifo size
// ----------------------------------------
`define SRA_CLK_MHZ 40
`define SRA_PROG_TIME_US 300
`define SRA_ERASE_TIME_MS 20
`define SRA_FIFO_DEPTH 16
`define SRA_FIFO_WIDTH 25

`endif

/* hdl/sra_fifo.sv */
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: one clock, DEPTH a power of two
// Notes: full shows as inReady low, empty as outValid low
`include "sra_defs.svh"
module sra_fifo #(
  parameter int WIDTH = `SRA_FIFO_WIDTH,
  parameter int DEPTH = `SRA_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } sra_fifo_t;

  sra_fifo_t s_ff;
  sra_fifo_t nxt_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady = s_ff.count != (AW+1)'(DEPTH);
  assign outValid = s_ff.count != '0;
  assign outData = mem[s_ff.rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.wrPtr = s_ff.wrPtr + 1'b1;
    end
    if (pop)
    begin
      nxt_s.rdPtr = s_ff.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_s.count = s_ff.count + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_s.count = s_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // storage is data, not control: no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[s_ff.wrPtr] <= inData;
    end
  end
endmodule

/* hdl/sra_pkg.sv */
// Purpose: types of the smbus ram/eeprom access block
// Assumes: nothing
// Notes: state structs hold every flip-flop except the memories
package sra_pkg;

  typedef enum logic [2:0] {L_IDLE, L_RX, L_RXWAIT, L_ACK, L_TXWAIT, L_TX, L_MACK} sra_lstate_t;

  typedef enum logic [3:0] {C_IDLE, C_CMD, C_RAMDATA, C_EELOW, C_EEDATA, C_BWCOUNT, C_BWDATA,
                            C_ERHI, C_ERLO, C_RDSINGLE, C_BRCOUNT, C_BRDATA, C_DONE} sra_cstate_t;

  typedef enum logic [1:0] {EV_START, EV_WRITE, EV_READ, EV_STOP} sra_ev_t;

  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclP;
    logic sdaS1;
    logic sdaS2;
    logic sdaP;
    logic ansS1;
    logic ansS2;
    sra_lstate_t st;
    logic [3:0] bitCnt;
    logic [7:0] shreg;
    logic first;
    logic rdMode;
    logic mack;
    logic sdaOeN;
    logic sclOeN;
    logic reqTog;
    sra_ev_t evKind;
    logic [7:0] evByte;
  } sra_link_t;

  typedef struct packed {
    logic [2:0] strS1;
    logic [2:0] strS2;
    logic [1:0] strCnt;
    logic strapDone;
    logic [2:0] slvLow;
    logic reqS1;
    logic reqS2;
    logic ansTog;
    logic ansAck;
    logic [7:0] ansData;
    sra_cstate_t st;
    logic [7:0] cmd;
    logic [7:0] erHi;
    logic [15:0] ptr;
    logic pinned;
    logic blkRd;
    logic [7:0] cnt;
    logic [23:0] engCnt;
  } sra_core_t;

endpackage

/* hdl/sra_smbus_access.sv */
// Purpose: smbus slave giving a bus master access to ram 00h-7fh and eeprom 8000h-813fh
// Assumes: scl/sda oversampled on linkClk, well above the bus rate; rst async high
// Notes: the slave stretches scl while the core answers each byte
`include "sra_defs.svh"
module sra_smbus_access #(
  parameter int RAM_USED = `SRA_RAM_BYTES,
  parameter int BLOCK_RD_LEN = `SRA_BLK_MAX,
  parameter int PROG_CYCLES = `SRA_PROG_TIME_US * `SRA_CLK_MHZ,
  parameter int ERASE_CYCLES = `SRA_ERASE_TIME_MS * 1000 * `SRA_CLK_MHZ,
  parameter int FIFO_DEPTH = `SRA_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic addrSelectPinHigh,
  input wire logic addrSelectPinFloat,
  input wire logic addrExtendBit,
  output logic eepromBusy
);
  localparam int FW = `SRA_FIFO_WIDTH;

  sra_pkg::sra_link_t l_ff;
  sra_pkg::sra_link_t nxt_l;
  sra_pkg::sra_core_t c_ff;
  sra_pkg::sra_core_t nxt_c;

  logic [7:0] ram [`SRA_RAM_BYTES];
  logic [7:0] ee [`SRA_EE_BYTES];

  logic pushValid;
  logic pushReady;
  logic [FW-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [FW-1:0] popData;
  logic ramWe;
  logic [6:0] ramA;
  logic [7:0] ramD;
  logic eeWe;
  logic [8:0] eeA;
  logic [7:0] eeD;
  logic eeErase;
  logic [8:0] erBase;

  // ----------------------------------------
  // address decoding helpers
  // ----------------------------------------
  function automatic logic isEe(input logic [15:0] a);
    return a[15:8] == `SRA_EE_HI_FRU || a[15:8] == `SRA_EE_HI_CFG;
  endfunction

  function automatic logic inRange(input logic [15:0] a);
    logic r;
    r = 1'b0;
    if (a[15:8] == `SRA_RAM_HI)
    begin
      r = a[7:0] <= `SRA_RAM_LIMIT && 32'(a[6:0]) < RAM_USED;
    end
    else if (a[15:8] == `SRA_EE_HI_FRU)
    begin
      r = 1'b1;
    end
    else if (a[15:8] == `SRA_EE_HI_CFG)
    begin
      r = a[7:0] <= `SRA_EE_CFG_LAST;
    end
    return r;
  endfunction

  function automatic logic [8:0] eeIdx(input logic [15:0] a);
    return a[8] ? {3'b100, a[5:0]} : {1'b0, a[7:0]};
  endfunction

  function automatic logic [7:0] rdByte(input logic [15:0] a, input logic pinned);
    logic [7:0] d;
    d = 8'h00;
    if (!pinned && inRange(a))
    begin
      d = isEe(a) ? ee[eeIdx(a)] : ram[a[6:0]];
    end
    return d;
  endfunction

  // returns {pinned, pointer}; a pointer at its limit stays and pins
  function automatic logic [16:0] nextPtr(input logic [15:0] a, input logic pinned, input logic pageLock);
    logic [7:0] lim;
    logic [16:0] r;
    lim = (a[15:8] == `SRA_EE_HI_CFG) ? `SRA_EE_CFG_LAST : `SRA_EE_FRU_LAST;
    r = {pinned, a + 16'h0001};
    if (pinned || a[7:0] == lim || (pageLock && isEe(a) && a[4:0] == `SRA_PAGE_LAST))
    begin
      r = {1'b1, a};
    end
    return r;
  endfunction

  // ----------------------------------------
  // link domain: pins, bit framing, scl stretch
  // ----------------------------------------
  logic lRise;
  logic lFall;
  logic lStart;
  logic lStop;
  logic lIdle;

  always_comb
  begin
    nxt_l = l_ff;
    nxt_l.sclS1 = sclIn;
    nxt_l.sclS2 = l_ff.sclS1;
    nxt_l.sclP = l_ff.sclS2;
    nxt_l.sdaS1 = sdaIn;
    nxt_l.sdaS2 = l_ff.sdaS1;
    nxt_l.sdaP = l_ff.sdaS2;
    nxt_l.ansS1 = c_ff.ansTog;
    nxt_l.ansS2 = l_ff.ansS1;
    lRise = l_ff.sclS2 & ~l_ff.sclP;
    lFall = ~l_ff.sclS2 & l_ff.sclP;
    lStart = l_ff.sclS2 & l_ff.sclP & l_ff.sdaP & ~l_ff.sdaS2;
    lStop = l_ff.sclS2 & l_ff.sclP & ~l_ff.sdaP & l_ff.sdaS2;
    lIdle = l_ff.reqTog == l_ff.ansS2;
    if (lStart)
    begin
      // a repeated start restarts framing; the core keeps its pointer
      nxt_l.st = sra_pkg::L_RX;
      nxt_l.bitCnt = 4'h0;
      nxt_l.first = 1'b1;
      nxt_l.rdMode = 1'b0;
      nxt_l.sdaOeN = 1'b1;
      nxt_l.sclOeN = 1'b1;
    end
    else if (lStop)
    begin
      nxt_l.st = sra_pkg::L_IDLE;
      nxt_l.sdaOeN = 1'b1;
      nxt_l.sclOeN = 1'b1;
      if (lIdle)
      begin
        nxt_l.evKind = sra_pkg::EV_STOP;
        nxt_l.reqTog = ~l_ff.reqTog;
      end
    end
    else
    begin
      case (l_ff.st)
        sra_pkg::L_RX:
        begin
          if (lRise)
          begin
            nxt_l.shreg = {l_ff.shreg[6:0], l_ff.sdaS2};
            nxt_l.bitCnt = l_ff.bitCnt + 4'h1;
          end
          else if (lFall && l_ff.bitCnt == 4'h8 && lIdle)
          begin
            // hold scl low until the core has decided the ack
            nxt_l.sclOeN = 1'b0;
            nxt_l.evKind = l_ff.first ? sra_pkg::EV_START : sra_pkg::EV_WRITE;
            nxt_l.evByte = l_ff.shreg;
            nxt_l.reqTog = ~l_ff.reqTog;
            nxt_l.st = sra_pkg::L_RXWAIT;
          end
        end
        sra_pkg::L_RXWAIT:
        begin
          if (lIdle)
          begin
            // an ack is driven first and scl let go one edge later, so sda never moves with scl high
            nxt_l.sclOeN = ~c_ff.ansAck;
            nxt_l.sdaOeN = ~c_ff.ansAck;
            nxt_l.rdMode = l_ff.first & l_ff.shreg[0] & c_ff.ansAck;
            nxt_l.st = c_ff.ansAck ? sra_pkg::L_ACK : sra_pkg::L_IDLE;
          end
        end
        sra_pkg::L_ACK:
        begin
          if (!l_ff.sclOeN)
          begin
            nxt_l.sclOeN = 1'b1;
          end
          else if (lFall)
          begin
            nxt_l.sdaOeN = 1'b1;
            nxt_l.first = 1'b0;
            nxt_l.bitCnt = 4'h0;
            nxt_l.st = sra_pkg::L_RX;
            if (l_ff.rdMode)
            begin
              nxt_l.sclOeN = 1'b0;
              nxt_l.evKind = sra_pkg::EV_READ;
              nxt_l.reqTog = ~l_ff.reqTog;
              nxt_l.st = sra_pkg::L_TXWAIT;
            end
          end
        end
        sra_pkg::L_TXWAIT:
        begin
          if (lIdle)
          begin
            nxt_l.shreg = c_ff.ansData;
            nxt_l.sdaOeN = c_ff.ansData[7];
            nxt_l.bitCnt = 4'h0;
            nxt_l.st = sra_pkg::L_TX;
          end
        end
        sra_pkg::L_TX:
        begin
          if (!l_ff.sclOeN)
          begin
            nxt_l.sclOeN = 1'b1;
          end
          else if (lFall)
          begin
            nxt_l.bitCnt = l_ff.bitCnt + 4'h1;
            nxt_l.shreg = {l_ff.shreg[6:0], 1'b0};
            nxt_l.sdaOeN = l_ff.shreg[6];
            if (l_ff.bitCnt == 4'h7)
            begin
              nxt_l.sdaOeN = 1'b1;
              nxt_l.mack = 1'b0;
              nxt_l.st = sra_pkg::L_MACK;
            end
          end
        end
        sra_pkg::L_MACK:
        begin
          if (lRise)
          begin
            nxt_l.mack = ~l_ff.sdaS2;
          end
          else if (lFall)
          begin
            // a master nack ends the read; only start or stop follow
            nxt_l.st = sra_pkg::L_IDLE;
            if (l_ff.mack)
            begin
              nxt_l.sclOeN = 1'b0;
              nxt_l.evKind = sra_pkg::EV_READ;
              nxt_l.reqTog = ~l_ff.reqTog;
              nxt_l.st = sra_pkg::L_TXWAIT;
            end
          end
        end
        default:
        begin
          nxt_l.st = sra_pkg::L_IDLE;
        end
      endcase
    end
  end

  // reset is asserted asynchronously; linkClk may stand still then
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      l_ff <= '{sclS1: 1'b1, sclS2: 1'b1, sclP: 1'b1, sdaS1: 1'b1, sdaS2: 1'b1, sdaP: 1'b1,
                st: sra_pkg::L_IDLE, evKind: sra_pkg::EV_STOP, sdaOeN: 1'b1, sclOeN: 1'b1, default: '0};
    end
    else
    begin
      l_ff <= nxt_l;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOeN = l_ff.sclOeN;
  assign sdaOeN = l_ff.sdaOeN;

  // ----------------------------------------
  // core domain: command layer and programming engine
  // ----------------------------------------
  logic evPend;
  logic evGo;
  logic needPush;
  logic busy;
  logic ack;
  logic [7:0] rdat;
  logic [7:0] b;
  logic [16:0] np;
  logic wpOk;
  logic [FW-1:0] w;

  assign busy = c_ff.engCnt != 24'h0 || popValid;
  assign eepromBusy = busy;

  always_comb
  begin
    nxt_c = c_ff;
    pushValid = 1'b0;
    pushData = '0;
    popReady = 1'b0;
    ramWe = 1'b0;
    ramA = 7'h00;
    ramD = 8'h00;
    eeWe = 1'b0;
    eeA = 9'h000;
    eeD = 8'h00;
    eeErase = 1'b0;
    erBase = 9'h000;
    ack = 1'b1;
    rdat = 8'h00;
    np = '0;
    w = popData;
    b = l_ff.evByte;
    wpOk = ram[`SRA_WP_REG][`SRA_WP_BIT];
    nxt_c.reqS1 = l_ff.reqTog;
    nxt_c.reqS2 = c_ff.reqS1;
    nxt_c.strS1 = {addrExtendBit, addrSelectPinFloat, addrSelectPinHigh};
    nxt_c.strS2 = c_ff.strS1;
    // straps are taken once, after they have passed the synchroniser
    if (!c_ff.strapDone)
    begin
      nxt_c.strCnt = c_ff.strCnt + 2'h1;
      if (c_ff.strCnt == 2'h3)
      begin
        nxt_c.strapDone = 1'b1;
        // a floating pin gives a2 and moves the extend bit down to a0
        nxt_c.slvLow = {c_ff.strS2[1], c_ff.strS2[2] & ~c_ff.strS2[1],
                        c_ff.strS2[1] ? c_ff.strS2[2] : c_ff.strS2[0]};
      end
    end
    evPend = c_ff.reqS2 != c_ff.ansTog;
    needPush = l_ff.evKind == sra_pkg::EV_WRITE && (c_ff.st == sra_pkg::C_RAMDATA ||
               c_ff.st == sra_pkg::C_EEDATA || c_ff.st == sra_pkg::C_BWDATA || c_ff.st == sra_pkg::C_ERLO);
    // a full fifo withholds the answer, so scl stays stretched
    evGo = evPend && !(needPush && !pushReady);
    if (evGo)
    begin
      case (l_ff.evKind)
        sra_pkg::EV_STOP:
        begin
          nxt_c.st = sra_pkg::C_IDLE;
          nxt_c.blkRd = 1'b0;
        end
        sra_pkg::EV_START:
        begin
          nxt_c.st = sra_pkg::C_IDLE;
          if (!c_ff.strapDone || b[7:1] != {`SRA_DEV_ADDR_HI, c_ff.slvLow})
          begin
            ack = 1'b0;
          end
          else if (!b[0])
          begin
            nxt_c.st = sra_pkg::C_CMD;
            nxt_c.blkRd = 1'b0;
          end
          else if (busy && isEe(c_ff.ptr))
          begin
            ack = 1'b0;
          end
          else
          begin
            nxt_c.st = c_ff.blkRd ? sra_pkg::C_BRCOUNT : sra_pkg::C_RDSINGLE;
          end
        end
        sra_pkg::EV_WRITE:
        begin
          case (c_ff.st)
            sra_pkg::C_CMD:
            begin
              nxt_c.cmd = b;
              nxt_c.st = sra_pkg::C_DONE;
              if (!b[7])
              begin
                nxt_c.ptr = {`SRA_RAM_HI, b};
                nxt_c.pinned = 1'b0;
                nxt_c.st = sra_pkg::C_RAMDATA;
              end
              else if (isEe({b, 8'h00}))
              begin
                ack = ~busy;
                nxt_c.st = busy ? sra_pkg::C_IDLE : sra_pkg::C_EELOW;
              end
              else if (b == `SRA_CMD_BLK_WR)
              begin
                ack = ~(busy && isEe(c_ff.ptr));
                nxt_c.st = ack ? sra_pkg::C_BWCOUNT : sra_pkg::C_IDLE;
              end
              else if (b == `SRA_CMD_BLK_RD)
              begin
                nxt_c.blkRd = 1'b1;
              end
              else if (b == `SRA_CMD_ERASE)
              begin
                ack = ~busy;
                nxt_c.st = busy ? sra_pkg::C_IDLE : sra_pkg::C_ERHI;
              end
              else
              begin
                ack = 1'b0;
                nxt_c.st = sra_pkg::C_IDLE;
              end
            end
            sra_pkg::C_RAMDATA:
            begin
              pushValid = inRange({`SRA_RAM_HI, c_ff.cmd});
              pushData = {1'b0, `SRA_RAM_HI, c_ff.cmd, b};
              nxt_c.st = sra_pkg::C_DONE;
            end
            sra_pkg::C_EELOW:
            begin
              nxt_c.ptr = {c_ff.cmd, b};
              nxt_c.pinned = 1'b0;
              nxt_c.st = sra_pkg::C_EEDATA;
            end
            sra_pkg::C_EEDATA:
            begin
              pushValid = wpOk && inRange(c_ff.ptr);
              pushData = {1'b0, c_ff.ptr, b};
              nxt_c.st = sra_pkg::C_DONE;
            end
            sra_pkg::C_BWCOUNT:
            begin
              nxt_c.cnt = (b > `SRA_BLK_MAX) ? `SRA_BLK_MAX : b;
              nxt_c.st = sra_pkg::C_BWDATA;
            end
            sra_pkg::C_BWDATA:
            begin
              if (c_ff.cnt == 8'h00)
              begin
                ack = 1'b0;
              end
              else
              begin
                pushValid = !c_ff.pinned && inRange(c_ff.ptr) && (wpOk || !isEe(c_ff.ptr));
                pushData = {1'b0, c_ff.ptr, b};
                np = nextPtr(c_ff.ptr, c_ff.pinned, 1'b1);
                nxt_c.pinned = np[16];
                nxt_c.ptr = np[15:0];
                nxt_c.cnt = c_ff.cnt - 8'h01;
              end
            end
            sra_pkg::C_ERHI:
            begin
              nxt_c.erHi = b;
              nxt_c.st = sra_pkg::C_ERLO;
            end
            sra_pkg::C_ERLO:
            begin
              pushValid = wpOk && inRange({c_ff.erHi, b[7:5], 5'h00});
              pushData = {1'b1, c_ff.erHi, b[7:5], 5'h00, 8'h00};
              nxt_c.st = sra_pkg::C_DONE;
            end
            default:
            begin
              ack = 1'b0;
            end
          endcase
        end
        default:
        begin
          case (c_ff.st)
            sra_pkg::C_RDSINGLE:
            begin
              rdat = rdByte(c_ff.ptr, c_ff.pinned);
            end
            sra_pkg::C_BRCOUNT:
            begin
              rdat = 8'(BLOCK_RD_LEN);
              nxt_c.st = sra_pkg::C_BRDATA;
            end
            sra_pkg::C_BRDATA:
            begin
              rdat = rdByte(c_ff.ptr, c_ff.pinned);
              np = nextPtr(c_ff.ptr, c_ff.pinned, 1'b0);
              nxt_c.pinned = np[16];
              nxt_c.ptr = np[15:0];
            end
            default:
            begin
              rdat = 8'h00;
            end
          endcase
        end
      endcase
      nxt_c.ansAck = ack;
      nxt_c.ansData = rdat;
      nxt_c.ansTog = c_ff.reqS2;
    end
    // one queued write or erase at a time; eeprom ops then hold off the queue
    if (c_ff.engCnt != 24'h0)
    begin
      nxt_c.engCnt = c_ff.engCnt - 24'h1;
    end
    else if (popValid)
    begin
      popReady = 1'b1;
      if (w[24])
      begin
        eeErase = 1'b1;
        erBase = eeIdx(w[23:8]);
        nxt_c.engCnt = 24'(ERASE_CYCLES);
      end
      else if (!isEe(w[23:8]))
      begin
        ramWe = 1'b1;
        ramA = w[14:8];
        ramD = w[7:0];
      end
      else
      begin
        // programming only clears bits; erased cells read as all ones
        eeWe = 1'b1;
        eeA = eeIdx(w[23:8]);
        eeD = ee[eeIdx(w[23:8])] & w[7:0];
        nxt_c.engCnt = 24'(PROG_CYCLES);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      c_ff <= '{st: sra_pkg::C_IDLE, default: '0};
    end
    else
    begin
      c_ff <= nxt_c;
    end
  end

  // ----------------------------------------
  // memories
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `SRA_RAM_BYTES; i++)
      begin
        ram[i] <= 8'h00;
      end
    end
    else if (ramWe)
    begin
      ram[ramA] <= ramD;
    end
  end

  // nonvolatile array: not cleared by reset
  always_ff @(posedge ref_clk)
  begin
    if (eeWe)
    begin
      ee[eeA] <= eeD;
    end
    if (eeErase)
    begin
      for (int i = 0; i < `SRA_PAGE_BYTES; i++)
      begin
        ee[erBase + 9'(i)] <= `SRA_EE_ERASED;
      end
    end
  end

  sra_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );
endmodule

/* tb/smbus_ram_eeprom_access_tb_top.sv */
// Purpose: self-checking bench of the smbus access block
// Assumes: sra_host plays the bus master
// Notes: short program and erase times keep the run brief
module smbus_ram_eeprom_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst = 1'b1;
  logic pinHigh, pinFloat, extBit, resStb;
  wire sclIn, sdaIn, sclOeN, sdaOeN, eepromBusy;
  logic [8:0] res;
  logic [2:0] low;
  logic [7:0] d;
  logic [8:0] expq[$];
  int seed = 32'h75ad;
  int errors = 0;
  int num_checks = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #32 linkClk = ~linkClk;
  end
  sra_smbus_access #(.BLOCK_RD_LEN(4), .PROG_CYCLES(600), .ERASE_CYCLES(900)) u_dut (.ref_clk(ref_clk),
    .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sclOut(), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(),
    .sdaOeN(sdaOeN), .addrSelectPinHigh(pinHigh), .addrSelectPinFloat(pinFloat), .addrExtendBit(extBit),
    .eepromBusy(eepromBusy));
  sra_host u_host (.clk(ref_clk), .sclOeN(sclOeN), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn),
    .res(res), .resStb(resStb));
  task automatic tx(input logic [7:0] v, input logic ok);
    expq.push_back({ok, v});
    u_host.xfer(v, 1'b1);
  endtask
  task automatic wr(input logic [7:0] b[$], input logic stop, input logic lastOk);
    u_host.st();
    tx({4'ha, low, 1'b0}, 1'b1);
    foreach (b[i])
      tx(b[i], (i < b.size() - 1) || lastOk);
    if (stop)
      u_host.sp();
  endtask
  task automatic rd(input logic [7:0] e[$]);
    u_host.st();
    tx({4'ha, low, 1'b1}, 1'b1);
    foreach (e[i])
    begin
      expq.push_back({i != e.size() - 1, e[i]});
      u_host.xfer(8'hff, i == e.size() - 1);
    end
    u_host.sp();
  endtask
  task automatic waitIdle;
    for (int i = 0; i < 3000 && eepromBusy !== 1'b0; i++)
      @(negedge ref_clk);
    num_checks++;
    if (eepromBusy !== 1'b0)
    begin
      errors++;
      $display("[ERR] %0t eeprom busy stuck", $time);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge resStb)
  begin
    num_checks++;
    if (expq.size() == 0 || res !== expq[0])
    begin
      errors++;
      $display("[ERR] %0t byte result %h", $time, res);
    end
    if (expq.size() != 0)
      void'(expq.pop_front());
  end
  initial
  begin
    {pinHigh, pinFloat, extBit} = 3'($random(seed));
    d = 8'($random(seed));
    low = {pinFloat, extBit & ~pinFloat, pinFloat ? extBit : pinHigh};
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    u_host.hw(12);
    u_host.st();
    tx({4'ha, ~low, 1'b0}, 1'b0);
    u_host.sp();
    wr('{8'h05, d}, 1'b1, 1'b1);
    wr('{8'h05}, 1'b0, 1'b1);
    rd('{d});
    rd('{d});
    wr('{8'h03, 8'h02}, 1'b1, 1'b1);
    wr('{8'h7d}, 1'b0, 1'b1);
    wr('{8'ha0, 8'h03, d, ~d, d ^ 8'h5a}, 1'b1, 1'b1);
    wr('{8'h7d}, 1'b0, 1'b1);
    wr('{8'ha1}, 1'b0, 1'b1);
    rd('{8'h04, d, ~d, d ^ 8'h5a, 8'h00});
    wr('{8'ha2, 8'h80, 8'h00}, 1'b1, 1'b1);
    wr('{8'h80}, 1'b1, 1'b0);
    waitIdle();
    wr('{8'h80, 8'h05, d}, 1'b1, 1'b1);
    wr('{8'h81}, 1'b1, 1'b0);
    waitIdle();
    wr('{8'h80, 8'h05}, 1'b0, 1'b1);
    rd('{d});
    wr('{8'ha2, 8'h81, 8'h20}, 1'b1, 1'b1);
    waitIdle();
    wr('{8'h81, 8'h3f}, 1'b0, 1'b1);
    wr('{8'ha0, 8'h02, d, ~d}, 1'b1, 1'b1);
    waitIdle();
    wr('{8'h81, 8'h3f}, 1'b0, 1'b1);
    wr('{8'ha1}, 1'b0, 1'b1);
    rd('{8'h04, d, 8'h00, 8'h00, 8'h00});
    test_done();
  end
  initial
  begin
    #1000000;
    errors++;
    test_done();
  end
endmodule

/* tb/sra_host.sv */
// Purpose: smbus master model
// Assumes: pull-ups on scl and sda
// Notes: steps on ref_clk falling edges
module sra_host (
  input wire logic clk,
  input wire logic sclOeN,
  input wire logic sdaOeN,
  output logic sclIn,
  output logic sdaIn,
  output logic [8:0] res,
  output logic resStb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hScl = 1'b1;
  logic hSda = 1'b1;
  initial res = 9'h000;
  initial resStb = 1'b0;
  // wired-and: a released line reads high
  assign sclIn = hScl & sclOeN;
  assign sdaIn = hSda & sdaOeN;
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  // low phase outlasts the slave's ack release, so a restart never looks like a stop
  task automatic st;
    hSda = 1'b1;
    hw(12);
    hScl = 1'b1;
    hw(12);
    hSda = 1'b0;
    hw(12);
    hScl = 1'b0;
  endtask
  task automatic sp;
    hSda = 1'b0;
    hw(12);
    hScl = 1'b1;
    wait (sclIn === 1'b1);
    hw(12);
    hSda = 1'b1;
    hw(12);
  endtask
  task automatic bitx(input logic b, output logic r);
    hSda = b;
    hw(12);
    hScl = 1'b1;
    wait (sclIn === 1'b1);
    hw(12);
    r = sdaIn;
    hScl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] v, input logic mNack);
    logic [7:0] q;
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], q[i]);
    bitx(mNack, a);
    res = {~a, q};
    resStb = 1'b1;
    hw(1);
    resStb = 1'b0;
  endtask
endmodule

/* tb/sra_smbus_monitor.sv */
// Purpose: pin checks of the smbus access block
// Assumes: bound to sra_smbus_access
// Notes: all checks run on linkClk
module sra_smbus_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOeN,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic eepromBusy
);
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> sclOeN && sdaOeN && !eepromBusy)
    else $error("pins active after reset");
  a_outs_zero: assert property (!sclOut && !sdaOut)
    else $error("open drain value not low");
  a_stretch_low: assert property ($fell(sclOeN) |-> !$past(sclIn))
    else $error("stretch began with scl high");
  a_stretch_bound: assert property ($fell(sclOeN) |-> ##[1:40] sclOeN)
    else $error("scl held too long");
  a_sda_pull_low: assert property ($fell(sdaOeN) |-> !sclIn)
    else $error("sda pulled while scl high");
  a_sda_stable: assert property (sclIn && $past(sclIn) |-> $stable(sdaOeN))
    else $error("sda moved while scl high");
  a_stop_quiet: assert property (sclIn && $rose(sdaIn) |-> (sdaOeN && sclOeN) [*4])
    else $error("slave active after stop");
  a_busy_bound: assert property ($rose(eepromBusy) |-> ##[1:500] !eepromBusy)
    else $error("eeprom busy too long");
  c_stretch: cover property ($fell(sclOeN));
  c_ack: cover property ($fell(sdaOeN));
  c_busy: cover property ($rose(eepromBusy));
endmodule

bind sra_smbus_access sra_smbus_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk),
  .sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
  .eepromBusy(eepromBusy));
